// [core/wdbr_supervisor.sv]
// Watchdog, brown-out mode control, bandgap enable and reset-cause flags behind APB
// Overview of operation
// - Brown-out reset after supply low for detect time, held until supply recovers
// - Sampled mode samples on falling edge of 1kHz from oscillator, detector off between
// - Sampled brown-out forces continuous mode until reset released and fuses reloaded
// - Active/idle setting: 00 reserved, 01 sampled, 10 continuous, 11 disabled
// - Deep-sleep setting uses same encoding for all sleep states except idle
// - Bandgap on only if detector on, comparator reference selected, or converter on
// - Watchdog counter runs on low-power oscillator ticks
// - Counter cleared by restart, while disabled, and on chip reset
// - Ten time-out periods selected by prescaler field
// - Time-out without restart requests chip reset
// - Time-out may raise an interrupt instead of a reset
// - Always-on fuse selects safety level one or two
// - Level one: enable bit set by plain write anytime
// - Level two: watchdog stays enabled, enable bit reads one
// - Level two period change needs signature; written enable value ignored
// - Reset-cause bits 7 to 4 read zero
// - Watchdog cause flag sets on watchdog reset, cleared by power-on or write zero
// - Brown-out cause flag sets on brown-out reset, same clearing
// - Pin cause flag sets on external reset, same clearing
// - Power-on flag sets on power-on, cleared only by writing zero
// - Codes 0 to 9 give 512 to 256K cycles; reserved codes fall back
// - Level one: enable forced set while watchdog cause flag set
// - Enable and irq enable: time-out raises irq and clears irq enable
// - Irq flag sets on irq time-out, cleared by vector taken or write one
//
// Chosen here: the APB register port.
module wdbr_supervisor
  import wdbr_pkg::*;
#(
  parameter int CNT_W = 19
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Oscillator tick and core events
  input wire logic osc_tick_i,
  input wire logic restart_i,
  input wire logic vector_taken_i,
  // Fuses and power state
  input wire logic fuse_load_i,
  input wire logic always_on_fuse_i,
  input wire logic [1:0] detector_active_setting_i,
  input wire logic [1:0] detector_sleep_setting_i,
  input wire logic deep_sleep_i,
  // Reset causes seen by this block
  input wire logic power_on_event_i,
  input wire logic pin_reset_event_i,
  input wire logic supply_low_i,
  // Outputs
  output logic detector_power_o,
  output logic bandgap_en_o,
  output logic brownout_reset_o,
  output logic watchdog_reset_o,
  output logic watchdog_irq_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic level2_reg;
  logic enable_reg;
  logic irq_en_reg;
  logic irq_flag_reg;
  logic [3:0] presc_reg;
  logic cmp_ref_reg;
  logic conv_en_reg;
  wdbr_cause_t cause_reg;
  logic [3:0] unlock_cnt_reg;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [4:0] div_cnt_reg;
  logic slow_clk_reg;
  logic forced_cont_reg;
  logic [15:0] low_cnt_reg;
  logic restart_pend_reg;
  logic wd_trig_reg;

  logic wr;
  logic rd;
  logic unlocked;
  logic eff_enable;
  logic running;
  logic [3:0] presc_eff;
  logic [CNT_W-1:0] limit;
  logic timeout;
  logic fall_tick;
  wdbr_det_mode_t sel_mode;
  wdbr_det_mode_t mode;
  logic sample_now;
  logic brown_now;

  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !penable_i && !pwrite_i;
  assign unlocked = unlock_cnt_reg != 4'h0;
  assign eff_enable = enable_reg || level2_reg || (!level2_reg && cause_reg.wdog);
  assign running = eff_enable || irq_en_reg;
  // reserved codes fall back to longest valid
  assign presc_eff = (presc_reg > WDBR_PRESC_MAX) ? WDBR_PRESC_MAX : presc_reg;
  assign limit = CNT_W'((1 << (WDBR_BASE_SHIFT + int'(presc_eff))) - 1);
  assign timeout = running && osc_tick_i && (wd_cnt_reg == limit);

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !(paddr_i == WDBR_RESET_CAUSE_OFF
        || paddr_i == WDBR_WDOG_CTRL_OFF || paddr_i == WDBR_PROTECT_OFF
        || paddr_i == WDBR_MISC_OFF || paddr_i == WDBR_STATUS_OFF);
      // Read data stands for the access cycle only, so unmapped and write accesses return zero
      prdata_o <= 32'h0000_0000;
      if (rd) begin
        if (paddr_i == WDBR_RESET_CAUSE_OFF) begin
          prdata_o <= {28'h000_0000, cause_reg};
        end else if (paddr_i == WDBR_WDOG_CTRL_OFF) begin
          prdata_o <= {24'h00_0000, irq_flag_reg, irq_en_reg, presc_reg[3], 1'b0,
                       eff_enable, presc_reg[2:0]};
        end else if (paddr_i == WDBR_PROTECT_OFF) begin
          prdata_o <= {31'h0000_0000, unlocked};
        end else if (paddr_i == WDBR_MISC_OFF) begin
          prdata_o <= {30'h0000_0000, conv_en_reg, cmp_ref_reg};
        end else if (paddr_i == WDBR_STATUS_OFF) begin
          prdata_o <= {27'h000_0000, level2_reg, forced_cont_reg, mode, brown_now};
        end else begin
          prdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Safety level and unlock window
  // ----------------------------------------
  // Fuse sampled only on fuse reloads, never under reset; level one until the first reload
  // level from always-on fuse
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      level2_reg <= 1'b0;
    end else if (fuse_load_i) begin
      level2_reg <= always_on_fuse_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      unlock_cnt_reg <= 4'h0;
    end else if (wr && paddr_i == WDBR_PROTECT_OFF && pwdata_i[7:0] == WDBR_SIGNATURE) begin
      unlock_cnt_reg <= 4'(WDBR_UNLOCK_CYC);
    end else if (wr && paddr_i == WDBR_WDOG_CTRL_OFF) begin
      unlock_cnt_reg <= 4'h0;
    end else if (unlocked) begin
      unlock_cnt_reg <= unlock_cnt_reg - 4'h1;
    end
  end

  // ----------------------------------------
  // Watchdog control register
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      enable_reg <= 1'b0;
      presc_reg <= 4'h0;
      irq_en_reg <= 1'b0;
    end else begin
      if (wr && paddr_i == WDBR_WDOG_CTRL_OFF) begin
        if (!level2_reg) begin
          if (pwdata_i[WDBR_CTRL_ENABLE_BIT] || unlocked) begin
            enable_reg <= pwdata_i[WDBR_CTRL_ENABLE_BIT];
          end
          if (unlocked || pwdata_i[WDBR_CTRL_ENABLE_BIT] == enable_reg || pwdata_i[WDBR_CTRL_ENABLE_BIT]) begin
            presc_reg <= {pwdata_i[WDBR_CTRL_PRESC3_BIT], pwdata_i[2:0]};
          end
          irq_en_reg <= pwdata_i[WDBR_CTRL_IRQ_EN_BIT];
        end else if (unlocked) begin
          // period change only in window, enable ignored
          presc_reg <= {pwdata_i[WDBR_CTRL_PRESC3_BIT], pwdata_i[2:0]};
        end
      end
      // irq enable cleared by time-out when enabled
      if (timeout && eff_enable && irq_en_reg) begin
        irq_en_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Watchdog counter on oscillator ticks
  // ----------------------------------------
  // restart held pending until the next oscillator tick
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      restart_pend_reg <= 1'b0;
    end else if (restart_i) begin
      restart_pend_reg <= 1'b1;
    end else if (osc_tick_i) begin
      restart_pend_reg <= 1'b0;
    end
  end

  // cleared on restart, disable and reset
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wd_cnt_reg <= '0;
    end else if (!running) begin
      wd_cnt_reg <= '0;
    end else if (osc_tick_i) begin
      if (restart_pend_reg || restart_i || timeout) begin
        wd_cnt_reg <= '0;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wd_trig_reg <= 1'b0;
      watchdog_reset_o <= 1'b0;
    end else begin
      wd_trig_reg <= timeout && !irq_en_reg && eff_enable;
      watchdog_reset_o <= wd_trig_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_flag_reg <= 1'b0;
    end else if (timeout && irq_en_reg) begin
      irq_flag_reg <= 1'b1;
    end else if (vector_taken_i || (wr && paddr_i == WDBR_WDOG_CTRL_OFF
                 && pwdata_i[WDBR_CTRL_IRQ_FLAG_BIT])) begin
      irq_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      watchdog_irq_o <= 1'b0;
    end else begin
      // Request follows the flag: a time-out that also drops irq enable must still interrupt
      watchdog_irq_o <= irq_flag_reg;
    end
  end

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  // Cause register survives its own reset only via events; event sets win over write clears, power-on clears win over sets
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cause_reg <= wdbr_cause_t'(WDBR_CAUSE_RESET[3:0]);
    end else begin
      if (wr && paddr_i == WDBR_RESET_CAUSE_OFF) begin
        cause_reg <= cause_reg & wdbr_cause_t'(pwdata_i[3:0]);
      end
      if (power_on_event_i) begin
        cause_reg.wdog <= 1'b0;
      end else if (wd_trig_reg) begin
        cause_reg.wdog <= 1'b1;
      end
      if (power_on_event_i) begin
        cause_reg.brown <= 1'b0;
      end else if (brown_now) begin
        cause_reg.brown <= 1'b1;
      end
      if (power_on_event_i) begin
        cause_reg.pin <= 1'b0;
      end else if (pin_reset_event_i) begin
        cause_reg.pin <= 1'b1;
      end
      if (power_on_event_i) begin
        cause_reg.power <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Brown-out detector modes
  // ----------------------------------------
  // active setting, or sleep setting in deep sleep
  assign sel_mode = wdbr_det_mode_t'(deep_sleep_i ? detector_sleep_setting_i : detector_active_setting_i);
  // Reserved code treated as continuous: safer than leaving the supply unwatched
  assign mode = forced_cont_reg ? WDBR_DET_CONT
              : (sel_mode == WDBR_DET_RSVD) ? WDBR_DET_CONT : sel_mode;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      div_cnt_reg <= 5'h00;
      slow_clk_reg <= 1'b0;
    end else if (osc_tick_i) begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
      if (div_cnt_reg == 5'(WDBR_OSC_PER_SAMPLE / 2 - 1) || div_cnt_reg == 5'(WDBR_OSC_PER_SAMPLE - 1)) begin
        slow_clk_reg <= !slow_clk_reg;
      end
    end
  end
  assign fall_tick = osc_tick_i && slow_clk_reg && div_cnt_reg == 5'(WDBR_OSC_PER_SAMPLE - 1);
  assign sample_now = (mode == WDBR_DET_SAMPLED) && fall_tick;

  // supply must stay low for a second clock cycle in continuous mode, counted in clock cycles
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      low_cnt_reg <= 16'h0000;
    end else if (mode == WDBR_DET_CONT && supply_low_i) begin
      if (low_cnt_reg != 16'hFFFF) begin
        low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
    end else begin
      low_cnt_reg <= 16'h0000;
    end
  end
  assign brown_now = (mode == WDBR_DET_CONT && supply_low_i && low_cnt_reg != 16'h0000)
                  || (sample_now && supply_low_i);

  // sampled hit latches continuous until fuses reload
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      forced_cont_reg <= 1'b0;
    end else if (sample_now && supply_low_i) begin
      forced_cont_reg <= 1'b1;
    end else if (fuse_load_i && !brownout_reset_o) begin
      forced_cont_reg <= 1'b0;
    end
  end

  // reset held while supply below level
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      brownout_reset_o <= 1'b0;
    end else if (brown_now) begin
      brownout_reset_o <= 1'b1;
    end else if (!supply_low_i) begin
      brownout_reset_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Misc register and reference enables
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cmp_ref_reg <= 1'b0;
      conv_en_reg <= 1'b0;
    end else if (wr && paddr_i == WDBR_MISC_OFF) begin
      cmp_ref_reg <= pwdata_i[WDBR_MISC_CMP_REF_BIT];
      conv_en_reg <= pwdata_i[WDBR_MISC_CONV_EN_BIT];
    end
  end

  // detector powered in continuous mode, otherwise only at sample instants
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bandgap_en_o <= 1'b0;
      detector_power_o <= 1'b0;
    end else begin
      bandgap_en_o <= (mode != WDBR_DET_OFF) || cmp_ref_reg || conv_en_reg;
      detector_power_o <= (mode == WDBR_DET_CONT) || sample_now;
    end
  end
endmodule

// [core/wdbr_pkg.sv]
// Package: register map, field layout, encodings and timing for the supervisory block
package wdbr_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] WDBR_RESET_CAUSE_OFF = 8'h34;
  localparam logic [7:0] WDBR_WDOG_CTRL_OFF = 8'h48;
  localparam logic [7:0] WDBR_PROTECT_OFF = 8'h4C;
  localparam logic [7:0] WDBR_MISC_OFF = 8'h50;
  localparam logic [7:0] WDBR_STATUS_OFF = 8'h54;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int WDBR_CAUSE_WDOG_BIT = 3;
  localparam int WDBR_CAUSE_BROWN_BIT = 2;
  localparam int WDBR_CAUSE_PIN_BIT = 1;
  localparam int WDBR_CAUSE_POWER_BIT = 0;
  localparam int WDBR_CTRL_IRQ_FLAG_BIT = 7;
  localparam int WDBR_CTRL_IRQ_EN_BIT = 6;
  localparam int WDBR_CTRL_PRESC3_BIT = 5;
  localparam int WDBR_CTRL_ENABLE_BIT = 3;
  localparam int WDBR_MISC_CMP_REF_BIT = 0;
  localparam int WDBR_MISC_CONV_EN_BIT = 1;
  // ----------------------------------------
  // Constants and timing
  // ----------------------------------------
  localparam logic [7:0] WDBR_SIGNATURE = 8'hD8;
  localparam int WDBR_UNLOCK_INSTR = 4;
  localparam int WDBR_CLK_MHZ = 250;
  localparam int WDBR_INSTR_NS = 4;
  localparam int WDBR_UNLOCK_CYC = WDBR_UNLOCK_INSTR * WDBR_INSTR_NS * WDBR_CLK_MHZ / 1000;
  localparam int WDBR_OSC_PER_SAMPLE = 32;
  localparam int WDBR_BASE_SHIFT = 9;
  localparam logic [3:0] WDBR_PRESC_MAX = 4'h9;
  localparam logic [7:0] WDBR_CAUSE_RESET = 8'h00;
  // ----------------------------------------
  // Detector modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    WDBR_DET_RSVD = 2'b00,
    WDBR_DET_SAMPLED = 2'b01,
    WDBR_DET_CONT = 2'b10,
    WDBR_DET_OFF = 2'b11
  } wdbr_det_mode_t;
  typedef struct packed {
    logic wdog;
    logic brown;
    logic pin;
    logic power;
  } wdbr_cause_t;
endpackage

// [bench/wdbr_supervisor_checker.sv]
// Port-level assertions for the supervisory block
module wdbr_supervisor_checker
  import wdbr_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Events and levels
  input wire logic vector_taken_i,
  input wire logic supply_low_i,
  input wire logic deep_sleep_i,
  input wire logic [1:0] detector_active_setting_i,
  // Outputs
  input wire logic brownout_reset_o,
  input wire logic watchdog_reset_o,
  input wire logic watchdog_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic setup;
  logic mapped;
  logic cont_low;
  assign setup = psel_i && !penable_i;
  assign mapped = paddr_i inside {WDBR_RESET_CAUSE_OFF, WDBR_WDOG_CTRL_OFF, WDBR_PROTECT_OFF, WDBR_MISC_OFF,
    WDBR_STATUS_OFF};
  assign cont_low = !deep_sleep_i && detector_active_setting_i == 2'b10 && supply_low_i;
  ready_next_a: assert property (setup |=> pready_o && !$past(pready_o))
    else $error("ready missing after setup");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  cause_rsvd_a: assert property (setup && !pwrite_i && paddr_i == WDBR_RESET_CAUSE_OFF |=> prdata_o[31:4] == '0)
    else $error("reserved cause bits not zero");
  wd_pulse_a: assert property (watchdog_reset_o |=> !watchdog_reset_o)
    else $error("watchdog reset pulse too long");
  bo_assert_a: assert property (cont_low [*5] |-> brownout_reset_o)
    else $error("brown-out reset missing");
  bo_hold_a: assert property (brownout_reset_o && supply_low_i |=> brownout_reset_o)
    else $error("brown-out reset released early");
  bo_release_a: assert property (!supply_low_i [*3] |-> !brownout_reset_o)
    else $error("brown-out reset held after recovery");
  vec_clr_a: assert property (vector_taken_i |-> ##2 !watchdog_irq_o)
    else $error("irq not cleared by vector");
  irq_not_rst_a: assert property ($rose(watchdog_irq_o) |-> !watchdog_reset_o)
    else $error("irq and reset together");
endmodule

bind wdbr_supervisor wdbr_supervisor_checker u_chk (.*);

// [bench/wdbr_core_model.sv]
// Core and oscillator model: ticks, restart and vector-taken pulses
module wdbr_core_model #(
  parameter int TICK_DIV = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Requests from the bench
  input wire logic restart_req_i,
  input wire logic vector_req_i,
  // Events to the block
  output logic osc_tick_o = 1'b0,
  output logic restart_o = 1'b0,
  output logic vector_taken_o = 1'b0
);
  int div_reg = 0;
  logic rs_q = 1'b0;
  logic vt_q = 1'b0;
  // free-running oscillator ticks
  // Runs through reset too, since the real oscillator never stops
  always @(posedge clock_i) begin
    div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
    osc_tick_o <= (div_reg == 0);
  end
  // One pulse per request, like one executed instruction
  always @(posedge clock_i) begin
    rs_q <= restart_req_i;
    vt_q <= vector_req_i;
    restart_o <= restart_req_i && !rs_q && rst_b_i;
    vector_taken_o <= vector_req_i && !vt_q && rst_b_i;
  end
endmodule

// [bench/tb.sv]
// Self-checking bench for the supervisory block
module tb
  import wdbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CAU = WDBR_RESET_CAUSE_OFF;
  localparam logic [7:0] CTL = WDBR_WDOG_CTRL_OFF;
  localparam logic [7:0] STA = WDBR_STATUS_OFF;
  logic clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [4:0] ev;
  logic osc_tick_i, restart_i, vector_taken_i, fuse_load_i, always_on_fuse_i, deep_sleep_i;
  logic power_on_event_i, pin_reset_event_i, supply_low_i;
  logic [1:0] detector_active_setting_i, detector_sleep_setting_i;
  logic detector_power_o, bandgap_en_o, brownout_reset_o, watchdog_reset_o, watchdog_irq_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int wd_cnt = 0;
  int n;
  assign power_on_event_i = ev[0];
  assign pin_reset_event_i = ev[1];
  assign fuse_load_i = ev[2];
  wdbr_supervisor DUT (.*);
  wdbr_core_model #(.TICK_DIV(2)) u_core (.clock_i, .rst_b_i, .restart_req_i(ev[3]), .vector_req_i(ev[4]),
    .osc_tick_o(osc_tick_i), .restart_o(restart_i), .vector_taken_o(vector_taken_i));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Hang guard, far above the roughly 8k cycles the run needs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (watchdog_reset_o === 1'b1) wd_cnt <= wd_cnt + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    tick(1);
    penable_i <= 1'b1;
    do tick(1); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask
  task automatic pulse(input logic [4:0] m);
    ev <= m;
    tick(1);
    ev <= 5'h00;
    tick(1);
  endtask
  task automatic unlock;
    bus(1'b1, WDBR_PROTECT_OFF, {24'h00_0000, WDBR_SIGNATURE});
  endtask
  task automatic off;
    unlock;
    bus(1'b1, CTL, 32'h0000_0000);
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, ev} = '0;
    {always_on_fuse_i, deep_sleep_i, supply_low_i} = '0;
    detector_active_setting_i = 2'b11;
    detector_sleep_setting_i = 2'b11;
    rst_b_i = 1'b0;
    tick(10);
    rst_b_i <= 1'b1;
    tick(1);
    rd(CAU, 32'h0000_0000);
    pulse(5'h01);
    pulse(5'h02);
    bus(1'b1, CAU, 32'hFFFF_FFFF);
    rd(CAU, 32'h0000_0003);
    pulse(5'h01);
    rd(CAU, 32'h0000_0001);
    bus(1'b1, CAU, 32'h0000_0000);
    rd(CAU, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk(e, 1'b1);
    $display("cause flags done");
    pulse(5'h04);
    rd(CTL, 32'h0000_0000);
    bus(1'b1, CTL, 32'h0000_0008);
    rd(CTL, 32'h0000_0008);
    bus(1'b1, WDBR_PROTECT_OFF, 32'h0000_00D7);
    bus(1'b1, CTL, 32'h0000_0000);
    rd(CTL, 32'h0000_0008);
    off;
    rd(CTL, 32'h0000_0000);
    bus(1'b1, CTL, 32'h0000_0008);
    n = 0;
    while (watchdog_reset_o !== 1'b1) begin
      tick(1);
      n++;
    end
    chk(32'(n >= 1000 && n <= 1040), 32'h1);
    rd(CAU, 32'h0000_0008);
    off;
    rd(CTL, 32'h0000_0008);
    bus(1'b1, CAU, 32'h0000_0000);
    off;
    rd(CTL, 32'h0000_0000);
    $display("level one done");
    bus(1'b1, CTL, 32'h0000_0008);
    repeat (3) begin
      tick(800);
      pulse(5'h08);
    end
    off;
    bus(1'b1, CTL, 32'h0000_0008);
    tick(800);
    chk(32'(wd_cnt), 32'h1);
    off;
    bus(1'b1, CTL, 32'h0000_0040);
    while (watchdog_irq_o !== 1'b1) tick(1);
    chk(32'(wd_cnt), 32'h1);
    rd(CTL, 32'h0000_00C0);
    pulse(5'h10);
    tick(2);
    rd(CTL, 32'h0000_0040);
    pulse(5'h08);
    bus(1'b1, CTL, 32'h0000_0048);
    tick(1100);
    chk(32'(wd_cnt), 32'h1);
    chk(watchdog_irq_o, 1'b1);
    rd(CTL, 32'h0000_0088);
    while (wd_cnt < 2) tick(1);
    bus(1'b1, CAU, 32'h0000_0000);
    bus(1'b1, CTL, 32'h0000_0088);
    rd(CTL, 32'h0000_0008);
    off;
    $display("watchdog done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, WDBR_MISC_OFF, 32'(i));
      tick(2);
      chk(bandgap_en_o, i != 0);
    end
    bus(1'b1, WDBR_MISC_OFF, 32'h0000_0000);
    detector_active_setting_i <= 2'b10;
    tick(3);
    chk({detector_power_o, bandgap_en_o}, 2'b11);
    deep_sleep_i <= 1'b1;
    tick(3);
    chk(detector_power_o, 1'b0);
    detector_sleep_setting_i <= 2'b00;
    tick(3);
    chk(detector_power_o, 1'b1);
    deep_sleep_i <= 1'b0;
    supply_low_i <= 1'b1;
    tick(8);
    chk(brownout_reset_o, 1'b1);
    supply_low_i <= 1'b0;
    tick(4);
    chk(brownout_reset_o, 1'b0);
    rd(CAU, 32'h0000_0004);
    detector_active_setting_i <= 2'b01;
    supply_low_i <= 1'b1;
    tick(200);
    chk(brownout_reset_o, 1'b1);
    supply_low_i <= 1'b0;
    tick(4);
    bus(1'b0, STA, 32'h0000_0000);
    chk(q[3], 1'b1);
    always_on_fuse_i <= 1'b1;
    pulse(5'h04);
    bus(1'b0, STA, 32'h0000_0000);
    chk(q[4:3], 2'b10);
    bus(1'b0, CTL, 32'h0000_0000);
    chk(q[3], 1'b1);
    unlock;
    bus(1'b1, CTL, 32'h0000_0001);
    rd(CTL, 32'h0000_0009);
    bus(1'b1, CTL, 32'h0000_0000);
    rd(CTL, 32'h0000_0009);
    $display("detector and level two done");
    report_and_stop;
  end
endmodule
